// ### core/addr_search_defines.svh
`ifndef ADDR_SEARCH_DEFINES_SVH
`define ADDR_SEARCH_DEFINES_SVH

// register byte offsets
`define OFS_SEARCH_CTRL 8'h30
`define OFS_CURSOR_LO 8'h31
`define OFS_CURSOR_HI 8'h32
`define OFS_MAC_VID_LO 8'h33
`define OFS_MAC_VID_HI 8'h3A
`define OFS_ENTRY_LO 8'h3B
`define OFS_ENTRY_HI 8'h3E
`define OFS_IRQ_STATUS 8'h50
`define OFS_IRQ_ENABLE 8'h51
`define OFS_IRQ_CLEAR 8'h52

// field positions
`define CTRL_START_BIT 7
`define CTRL_READY_BIT 0
`define CURSOR_VALID_BIT 15
`define IRQ_FOUND_BIT 0
`define IRQ_DONE_BIT 1

// reset values
`define RST_BYTE 8'h00
`define RST_CURSOR 16'h0000
`define RST_MAC_VID 64'h0000_0000_0000_0000
`define RST_ENTRY 32'h0000_0000
`define RST_IRQ 2'h0

// timing
`define AGE_PERIOD_DEFAULT 1000000

`endif

// ### core/addr_search_pkg.sv
package addr_search_pkg;

	typedef struct packed {
		logic [47:0] mac;
		logic [11:0] vid;
		logic [16:0] map;
		logic stat;
		logic age;
		logic valid;
		logic [2:0] prio;
	} entry_t;

	typedef enum logic [1:0] {
		SRCH_IDLE,
		SRCH_SCAN,
		SRCH_LOAD,
		SRCH_HOLD
	} search_state_t;

endpackage

// ### core/entry_fmt_if.sv
interface entry_fmt_if;
	import addr_search_pkg::*;

	entry_t ent;
	logic [63:0] mac_vid;
	logic [31:0] result;

	modport src (output ent, input mac_vid, input result);
	modport fmt (input ent, output mac_vid, output result);
endinterface

// ### core/entry_formatter.sv
module entry_formatter
	import addr_search_pkg::*;
(
	entry_fmt_if.fmt bus
);

	// mac/vid result word
	assign bus.mac_vid = {4'h0, bus.ent.vid, bus.ent.mac};

	// entry result word, layout depends on group bit of the address
	always_comb begin
		if (bus.ent.mac[47]) begin
			bus.result = {10'h000, bus.ent.map[16:6], bus.ent.map[5:1], bus.ent.map[0],
				bus.ent.age, bus.ent.valid, bus.ent.prio};
		end else begin
			bus.result = {10'h000, 11'h000, bus.ent.map[4:0], bus.ent.stat,
				bus.ent.age, bus.ent.valid, bus.ent.prio};
		end
	end

endmodule

// ### core/addr_table_search.sv
// Behaviour
// - The cursor valid bit clears itself and is set only while the low fifteen cursor bits hold the scrambled encoding of the entry being visited.
// - The fifteen-bit cursor holds an internal encoding of the visited entry for diagnostics, not a table location.
// - The found entry's VLAN identifier sits in bits 59:48 of the mac/vid result.
// - The found entry's 48-bit station address sits read-only in bits 47:0 of the mac/vid result.
// - For a unicast address bits 10:6 of the entry result carry the station port number.
// - For a group address the entry result carries portmap bits 16:6 in 21:11, 5:1 in 10:6 and bit 0 in bit 5.
// - For a unicast entry bit 5 is the static flag, and static entries are never changed by learning or aging.
// - Bit 4 is the age flag, set on learning or access and cleared by the aging sweep.
// - Aging clears the valid flag of a valid non-static entry left unused for one age period.
// - The age flag is ignored for static entries, which never age out.
// - Bit 3 is the valid flag, cleared when the entry is empty, aged out or invalidated by management.
// - Automatic learning writes only into locations that are neither valid nor static.
// - Bits 2:0 carry the entry's three-bit priority.
// - Writing one to the start bit begins a scan of occupied entries and the bit clears when the table is done.
// - The result ready flag rises when an entry is loaded and falls on the host read of the entry result top byte (8'h3E), which resumes the scan.
//
// Local design decision: the strobed register port.
`include "addr_search_defines.svh"

module addr_table_search
	import addr_search_pkg::*;
#(
	parameter int DEPTH = 4096,
	parameter int AGE_PERIOD = `AGE_PERIOD_DEFAULT
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// learning from the forwarding path
	input wire logic learn_req,
	input wire logic [47:0] learn_mac,
	input wire logic [11:0] learn_vid,
	input wire logic [4:0] learn_port,
	input wire logic [2:0] learn_prio,
	// lookup hit marks an entry as used
	input wire logic hit_req,
	input wire logic [$clog2(DEPTH)-1:0] hit_index,
	// management processor entry writes
	input wire logic mgmt_we,
	input wire logic [$clog2(DEPTH)-1:0] mgmt_index,
	input wire logic [47:0] mgmt_mac,
	input wire logic [11:0] mgmt_vid,
	input wire logic [16:0] mgmt_map,
	input wire logic mgmt_static,
	input wire logic mgmt_valid,
	input wire logic [2:0] mgmt_prio,
	// interrupt
	output logic irq
);

	localparam int IW = $clog2(DEPTH);

	// elaboration checks on the parameters
	if (DEPTH < 2 || DEPTH > 32768 || (1 << IW) != DEPTH) begin
		$error("DEPTH must be a power of two from 2 to 32768");
	end
	if (AGE_PERIOD < 1) begin
		$error("AGE_PERIOD must be at least one cycle");
	end

	//////////////////////////////////////////////////////////////////////////////////
	// table storage

	logic [47:0] mac_mem [DEPTH];
	logic [11:0] vid_mem [DEPTH];
	logic [16:0] map_mem [DEPTH];
	logic [2:0] prio_mem [DEPTH];
	logic [DEPTH-1:0] valid_r;
	logic [DEPTH-1:0] static_r;
	logic [DEPTH-1:0] age_r;

	logic [47:0] hash_mix;
	logic [IW-1:0] learn_idx;
	logic learn_match;
	logic learn_free;
	logic learn_wr;
	logic learn_touch;

	assign hash_mix = learn_mac ^ {36'h0_0000_0000, learn_vid};
	assign learn_idx = hash_mix[IW-1:0];
	assign learn_match = valid_r[learn_idx] && mac_mem[learn_idx] == learn_mac
		&& vid_mem[learn_idx] == learn_vid;
	assign learn_free = !valid_r[learn_idx] && !static_r[learn_idx];
	assign learn_wr = learn_req && !mgmt_we && learn_free;
	assign learn_touch = learn_req && !mgmt_we && learn_match && !static_r[learn_idx];

	always_ff @(posedge sys_clk) begin
		if (mgmt_we) begin
			mac_mem[mgmt_index] <= mgmt_mac;
			vid_mem[mgmt_index] <= mgmt_vid;
			map_mem[mgmt_index] <= mgmt_map;
			prio_mem[mgmt_index] <= mgmt_prio;
		end else if (learn_wr) begin
			mac_mem[learn_idx] <= learn_mac;
			vid_mem[learn_idx] <= learn_vid;
			map_mem[learn_idx] <= {12'h000, learn_port};
			prio_mem[learn_idx] <= learn_prio;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// aging sweep

	logic [31:0] age_cnt_r;
	logic age_sweep_r;
	logic [IW-1:0] age_idx_r;
	logic age_busy;

	// the sweep yields a slot whenever management or learning writes
	assign age_busy = mgmt_we || learn_wr || learn_touch;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			age_cnt_r <= 32'h0000_0000;
			age_sweep_r <= 1'b0;
			age_idx_r <= '0;
		end else if (!age_sweep_r) begin
			if (age_cnt_r == 32'(AGE_PERIOD - 1)) begin
				age_cnt_r <= 32'h0000_0000;
				age_sweep_r <= 1'b1;
			end else begin
				age_cnt_r <= age_cnt_r + 32'h0000_0001;
			end
		end else if (!age_busy) begin
			age_idx_r <= age_idx_r + 1'b1;
			if (age_idx_r == IW'(DEPTH - 1))
				age_sweep_r <= 1'b0;
		end
	end

	logic age_step;
	assign age_step = age_sweep_r && !age_busy && !static_r[age_idx_r];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			valid_r <= '0;
		end else begin
			if (age_step && valid_r[age_idx_r] && !age_r[age_idx_r])
				valid_r[age_idx_r] <= 1'b0;
			if (learn_wr)
				valid_r[learn_idx] <= 1'b1;
			if (mgmt_we)
				valid_r[mgmt_index] <= mgmt_valid;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			static_r <= '0;
		end else if (mgmt_we) begin
			static_r[mgmt_index] <= mgmt_static;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			age_r <= '0;
		end else begin
			if (age_step && valid_r[age_idx_r])
				age_r[age_idx_r] <= 1'b0;
			if (hit_req && valid_r[hit_index] && !static_r[hit_index])
				age_r[hit_index] <= 1'b1;
			if (learn_wr || learn_touch)
				age_r[learn_idx] <= 1'b1;
			if (mgmt_we)
				age_r[mgmt_index] <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	// search engine

	search_state_t state_r;
	logic [IW-1:0] scan_idx_r;
	logic ready_r;
	logic start_wr;
	logic result_read;
	logic found_ev;
	logic done_ev;

	assign start_wr = reg_wr && reg_addr == `OFS_SEARCH_CTRL && reg_wdata[`CTRL_START_BIT];
	assign result_read = reg_rd && reg_addr == `OFS_ENTRY_HI;

	entry_fmt_if fmt_bus ();

	assign fmt_bus.ent = '{mac: mac_mem[scan_idx_r], vid: vid_mem[scan_idx_r],
		map: map_mem[scan_idx_r], stat: static_r[scan_idx_r], age: age_r[scan_idx_r],
		valid: valid_r[scan_idx_r], prio: prio_mem[scan_idx_r]};

	entry_formatter u_entry_formatter (
		.bus(fmt_bus)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= SRCH_IDLE;
			scan_idx_r <= '0;
		end else begin
			case (state_r)
				SRCH_IDLE: begin
					if (start_wr) begin
						scan_idx_r <= '0;
						state_r <= SRCH_SCAN;
					end
				end
				SRCH_SCAN: begin
					if (valid_r[scan_idx_r]) begin
						state_r <= SRCH_LOAD;
					end else if (scan_idx_r == IW'(DEPTH - 1)) begin
						state_r <= SRCH_IDLE;
					end else begin
						scan_idx_r <= scan_idx_r + 1'b1;
					end
				end
				SRCH_LOAD: begin
					state_r <= SRCH_HOLD;
				end
				SRCH_HOLD: begin
					if (result_read) begin
						if (scan_idx_r == IW'(DEPTH - 1)) begin
							state_r <= SRCH_IDLE;
						end else begin
							scan_idx_r <= scan_idx_r + 1'b1;
							state_r <= SRCH_SCAN;
						end
					end
				end
				default: begin
					state_r <= SRCH_IDLE;
				end
			endcase
		end
	end

	assign found_ev = state_r == SRCH_LOAD;
	assign done_ev = (state_r == SRCH_SCAN && !valid_r[scan_idx_r]
		&& scan_idx_r == IW'(DEPTH - 1))
		|| (state_r == SRCH_HOLD && result_read && scan_idx_r == IW'(DEPTH - 1));

	// result words are captured while the ready flag is still low
	logic [63:0] mac_vid_r;
	logic [31:0] result_r;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mac_vid_r <= `RST_MAC_VID;
			result_r <= `RST_ENTRY;
		end else if (state_r == SRCH_SCAN && valid_r[scan_idx_r]) begin
			mac_vid_r <= fmt_bus.mac_vid;
			result_r <= fmt_bus.result;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready_r <= 1'b0;
		end else if (found_ev) begin
			ready_r <= 1'b1;
		end else if (result_read) begin
			ready_r <= 1'b0;
		end
	end

	logic searching;
	logic [15:0] cursor;
	assign searching = state_r != SRCH_IDLE;
	// position is scrambled so it is not a plain table index, and reads zero when idle
	assign cursor = searching ? {1'b1, 15'(scan_idx_r) ^ 15'h5555} : `RST_CURSOR;

	//////////////////////////////////////////////////////////////////////////////////
	// interrupts

	logic [1:0] irq_stat_r;
	logic [1:0] irq_en_r;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;

	assign irq_set = {done_ev, found_ev};
	assign irq_clr = (reg_wr && reg_addr == `OFS_IRQ_CLEAR) ? reg_wdata[1:0] : 2'h0;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_r <= `RST_IRQ;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_en_r <= `RST_IRQ;
		end else if (reg_wr && reg_addr == `OFS_IRQ_ENABLE) begin
			irq_en_r <= reg_wdata[1:0];
		end
	end

	assign irq = |(irq_stat_r & irq_en_r);

	//////////////////////////////////////////////////////////////////////////////////
	// register read port

	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = `RST_BYTE;
		if (reg_addr == `OFS_SEARCH_CTRL) begin
			rd_mux = {searching, 6'h00, ready_r};
		end else if (reg_addr == `OFS_CURSOR_LO) begin
			rd_mux = cursor[7:0];
		end else if (reg_addr == `OFS_CURSOR_HI) begin
			rd_mux = cursor[15:8];
		end else if (reg_addr >= `OFS_MAC_VID_LO && reg_addr <= `OFS_MAC_VID_HI) begin
			rd_mux = mac_vid_r[8 * (reg_addr - `OFS_MAC_VID_LO) +: 8];
		end else if (reg_addr >= `OFS_ENTRY_LO && reg_addr <= `OFS_ENTRY_HI) begin
			rd_mux = result_r[8 * (reg_addr - `OFS_ENTRY_LO) +: 8];
		end else if (reg_addr == `OFS_IRQ_STATUS) begin
			rd_mux = {6'h00, irq_stat_r};
		end else if (reg_addr == `OFS_IRQ_ENABLE) begin
			rd_mux = {6'h00, irq_en_r};
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= `RST_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= `RST_BYTE;
		end
	end

endmodule

// ### testbench/addr_search_chk.sv
module addr_search_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// interrupt
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic ctrl_rd_r;
	logic ready_r;
	////////////////////////////////
	// ready seen and not yet consumed
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_rd_r <= 1'b0;
		end else begin
			ctrl_rd_r <= reg_rd && reg_addr == 8'h30;
		end
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready_r <= 1'b0;
		end else if (reg_rd && reg_addr == 8'h3E) begin
			ready_r <= 1'b0;
		end else if (ctrl_rd_r && reg_rdata[0]) begin
			ready_r <= 1'b1;
		end
	end
	////////////////////////////////
	a_idle_rdata: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h3F |=> reg_rdata == 8'h00)
		else $error("unmapped byte not zero");
	a_entry_top_zero: assert property (reg_rd && reg_addr == 8'h3E |=> reg_rdata == 8'h00)
		else $error("entry result top byte not zero");
	a_macvid_top_zero: assert property (reg_rd && reg_addr == 8'h3A |=> reg_rdata[7:4] == 4'h0)
		else $error("mac vid top nibble not zero");
	a_ctrl_resv_zero: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[6:1] == 6'h00)
		else $error("control reserved bits set");
	a_start_cursor_valid: assert property (reg_wr && reg_addr == 8'h30 && reg_wdata[7] ##2
		reg_rd && reg_addr == 8'h32 |=> reg_rdata[7])
		else $error("cursor valid low after start");
	a_irq_fall_write: assert property ($fell(irq) |-> $past(reg_wr))
		else $error("irq fell without a write");
	a_ready_holds: assert property (ready_r && reg_rd && reg_addr == 8'h30 |=> reg_rdata[0])
		else $error("ready lost without entry read");
	c_ready: cover property (ready_r);
	c_entry_read: cover property (reg_rd && reg_addr == 8'h3E);
	c_irq_fall: cover property ($fell(irq));
endmodule

bind addr_table_search addr_search_chk u_addr_search_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .irq(irq));

// ### testbench/tb_addr_table_search.sv
module tb_addr_table_search;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic learn_req = 1'b0;
	logic [47:0] learn_mac = 48'h0;
	logic [11:0] learn_vid = 12'h000;
	logic [4:0] learn_port = 5'h00;
	logic [2:0] learn_prio = 3'h0;
	logic mgmt_we = 1'b0;
	logic [3:0] mgmt_index = 4'h0;
	logic [47:0] mgmt_mac = 48'h0;
	logic [11:0] mgmt_vid = 12'h000;
	logic [16:0] mgmt_map = 17'h00000;
	logic mgmt_static = 1'b0;
	logic [2:0] mgmt_prio = 3'h0;
	logic mgmt_valid = 1'b1;
	logic hit_req = 1'b0;
	logic [3:0] hit_index = 4'h0;
	logic irq;
	logic [7:0] rd_v;
	int errors = 0;
	int cmp_count = 0;

	always #12.5 sys_clk = ~sys_clk;

	addr_table_search #(.DEPTH(16), .AGE_PERIOD(20)) u_addr_table_search (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .learn_req(learn_req),
		.learn_mac(learn_mac), .learn_vid(learn_vid), .learn_port(learn_port),
		.learn_prio(learn_prio), .hit_req(hit_req), .hit_index(hit_index), .mgmt_we(mgmt_we),
		.mgmt_index(mgmt_index), .mgmt_mac(mgmt_mac), .mgmt_vid(mgmt_vid),
		.mgmt_map(mgmt_map), .mgmt_static(mgmt_static), .mgmt_valid(mgmt_valid),
		.mgmt_prio(mgmt_prio), .irq(irq));
	////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= rd;
		reg_wr <= !rd;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		#1 rd_v = reg_rdata;
	endtask
	task automatic mg(input logic [3:0] i, input logic [47:0] m, input logic [11:0] v,
		input logic [16:0] p, input logic s, input logic [2:0] pr);
		@(posedge sys_clk);
		mgmt_we <= 1'b1;
		mgmt_index <= i;
		mgmt_mac <= m;
		mgmt_vid <= v;
		mgmt_map <= p;
		mgmt_static <= s;
		mgmt_prio <= pr;
		@(posedge sys_clk);
		mgmt_we <= 1'b0;
	endtask
	task automatic ln(input logic [47:0] m, input logic [11:0] v, input logic [4:0] p);
		@(posedge sys_clk);
		learn_req <= 1'b1;
		learn_mac <= m;
		learn_vid <= v;
		learn_port <= p;
		learn_prio <= 3'h3;
		@(posedge sys_clk);
		learn_req <= 1'b0;
	endtask
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			acc(1'b1, 8'h30, 8'h00);
			n++;
		end while (rd_v[b] !== v && n < 100);
		chk(rd_v[b], v);
	endtask
	task automatic entry(input logic [63:0] mv, input logic [31:0] er);
		logic [63:0] gm;
		logic [31:0] ge;
		poll(0, 1'b1);
		acc(1'b1, 8'h30, 8'h00);
		chk(rd_v[0], 1'b1);
		chk(irq, 1'b1);
		acc(1'b0, 8'h3B, 8'hFF);
		acc(1'b0, 8'h33, 8'hFF);
		for (int k = 0; k < 8; k++) begin
			acc(1'b1, 8'h33 + k[7:0], 8'h00);
			gm[8*k +: 8] = rd_v;
		end
		for (int k = 0; k < 4; k++) begin
			acc(1'b1, 8'h3B + k[7:0], 8'h00);
			ge[8*k +: 8] = rd_v;
		end
		chk(gm, mv);
		chk(ge, er);
		acc(1'b1, 8'h30, 8'h00);
		chk(rd_v[0], 1'b0);
	endtask
	////////////////////////////////
	task automatic t_reset();
		for (int a = 8'h30; a < 8'h40; a++) begin
			acc(1'b1, a[7:0], 8'h00);
			chk(rd_v, 8'h00);
		end
		chk(irq, 1'b0);
	endtask
	task automatic t_load();
		mg(4'h3, 48'h0012_3456_789A, 12'h5A5, 17'h00013, 1'b1, 3'h5);
		mg(4'hC, 48'h8100_00AB_CDEF, 12'hFFF, 17'h1ABCD, 1'b1, 3'h2);
		mg(4'h7, 48'h0000_0000_0AB7, 12'h000, 17'h00001, 1'b0, 3'h1);
		ln(48'h0000_0000_0013, 12'h010, 5'h07);
		ln(48'h0000_0000_0045, 12'h000, 5'h02);
		repeat (200) @(posedge sys_clk);
	endtask
	task automatic t_search();
		acc(1'b0, 8'h51, 8'h01);
		acc(1'b0, 8'h30, 8'h80);
		acc(1'b1, 8'h32, 8'h00);
		chk(rd_v[7], 1'b1);
		entry(64'h05A5_0012_3456_789A, 32'h0000_04FD);
		entry(64'h0FFF_8100_00AB_CDEF, 32'h0035_79BA);
		poll(7, 1'b0);
		acc(1'b1, 8'h32, 8'h00);
		chk(rd_v[7], 1'b0);
		acc(1'b1, 8'h50, 8'h00);
		chk(rd_v, 8'h03);
	endtask
	task automatic t_irq();
		acc(1'b0, 8'h52, 8'h01);
		chk(irq, 1'b0);
		acc(1'b0, 8'h51, 8'h02);
		chk(irq, 1'b1);
		acc(1'b1, 8'h51, 8'h00);
		chk(rd_v, 8'h02);
		acc(1'b0, 8'h52, 8'h03);
		chk(irq, 1'b0);
		acc(1'b1, 8'h50, 8'h00);
		chk(rd_v, 8'h00);
	endtask
	task automatic t_hit();
		@(posedge sys_clk);
		hit_req <= 1'b1;
		hit_index <= 4'h9;
		mg(4'h9, 48'h0000_0000_0A09, 12'h123, 17'h0001F, 1'b0, 3'h7);
		mgmt_valid <= 1'b0;
		mg(4'h3, 48'h0012_3456_789A, 12'h5A5, 17'h00013, 1'b1, 3'h5);
		mgmt_valid <= 1'b1;
		repeat (150) @(posedge sys_clk);
		acc(1'b0, 8'h51, 8'h01);
		acc(1'b0, 8'h30, 8'h80);
		entry(64'h0123_0000_0000_0A09, 32'h0000_07DF);
		entry(64'h0FFF_8100_00AB_CDEF, 32'h0035_79BA);
		poll(7, 1'b0);
		@(posedge sys_clk);
		hit_req <= 1'b0;
	endtask
	task automatic conclude();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////
	initial begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_load();
		t_search();
		t_irq();
		t_hit();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		conclude();
	end
endmodule
